/* sdrc_ctrl.sv */
// SDRAM controller with ECC, processor-bus slave side and SDRAM side.
// Assumes bus and SDRAM share ref_clk_in; devices already initialised.
// Notes on behaviour
// - Correct single-bit, detect double-bit errors over 72-bit stored word.
// - Installed memory may total 32MB, 64MB or 128MB.
// - Byte-wide 64Mbit parts: up to two blocks of nine, 64MB each.
// - Nibble-wide 64Mbit parts: one block of eighteen, 128MB.
// - Blocks A and B are addressed and tracked independently.
// - Burst read from idle: first beat 10 closed, 12 miss, 7 hit.
// - Burst read after burst read: 5 on miss, 2/3 alternating on hit.
// - Burst write from idle: first beat after 4 clocks.
// - Burst write after burst write, page miss: first beat after 6.
// - Burst write page-hit chain: 3 for second, then 2 each.
// - Single read from idle: 10 closed, 12 miss, 7 hit.
// - Single read after single read: 8 miss, 5 hit.
// - Single write from idle completes in 5 clocks.
// - Single write after single write: 13 miss, 8 hit.
// - Command timing uses CAS latency 2, tRCD 2, tRP 2.
// - Timing also assumes tRAS 5, tRC 7, tDPL 2.
// - SDRAM command outputs leave flops directly, no extra stage.
// - Idle latency counts from the TS edge to the first TA edge.
// - Back-to-back latency counts from last TA to next first TA.
// - Later beats follow one clock apart within a burst.
// - A cache line is 32 bytes: four 64-bit beats.
`include "sdrc_defs.svh"
module sdrc_ctrl (
  input wire logic ref_clk_in, // Bus and SDRAM clock
  input wire logic resetn_in, // Synchronous reset, low
  input wire logic ce_in, // Clock enable, freezes state
  input sdrc_pkg::sdrc_org_type cfg_org_in, // Device organisation
  input wire logic ts_n_in, // Transfer start, low
  input sdrc_pkg::sdrc_req_type req_in, // Request with TS
  input wire logic [`SDRC_DATA_W-1:0] din_in, // Write beat data
  output logic aack_n_out, // Address acknowledge, low
  output logic ta_n_out, // Transfer acknowledge, low
  output logic [`SDRC_DATA_W-1:0] dout_out, // Read beat data
  output sdrc_pkg::sdrc_cmd_type sd_cmd_out, // SDRAM command
  input wire logic [`SDRC_WORD_W-1:0] sd_dq_in, // SDRAM data in
  output logic [`SDRC_WORD_W-1:0] sd_dq_out, // SDRAM data out
  output logic sd_dq_oe_out, // SDRAM data drive enable
  output logic sd_dqm_out, // SDRAM data mask
  output logic ecc_sbe_out, // Corrected error pulse
  output logic ecc_dbe_out // Uncorrectable error pulse
);
  import sdrc_pkg::*;

  generate
    if (`SDRC_BEATS * `SDRC_DATA_W / 8 != `SDRC_LINE_BYTES) begin : g_chk
      $error("Beat count and width must form one cache line");
    end
    // Beat and capture indices are two bits wide
    if (`SDRC_BEATS != 4) begin : g_chk_beats
      $error("Beat counters serve four-beat bursts only");
    end
    // Read return pipe shifts through at least two stages
    if (`SDRC_CAS_LAT < 2) begin : g_chk_cas
      $error("Read pipe needs a CAS latency of two or more");
    end
    // Word address must hold column, bank and row
    if (`SDRC_COL_W + `SDRC_BANK_W + `SDRC_ROW_W >
        `SDRC_WADDR_W) begin : g_chk_split
      $error("Word address too narrow for the address split");
    end
    if (`SDRC_WADDR_W != `SDRC_ADDR_W - `SDRC_BEAT_LSB) begin : g_chk_waddr
      $error("Word address width must match byte address width");
    end
    // Longest command lead must fit the latency counter
    if (`SDRC_RPRE_LEAD >= (1 << `SDRC_CNT_W)) begin : g_chk_cnt
      $error("Latency counter too narrow for the command leads");
    end
  endgenerate

  sdrc_state_type q;
  sdrc_state_type n;
  sdrc_req_type nreq;
  sdrc_page_type pg;
  logic [`SDRC_WORD_W-1:0] enc_word;
  logic [`SDRC_DATA_W-1:0] dec_data;
  logic dec_sbe;
  logic dec_dbe;
  logic accept;
  logic do_start;
  logic b2b;
  logic same;
  logic rd_go;
  logic [4:0] colw;
  logic [`SDRC_WADDR_W-1:0] w;
  logic [`SDRC_WADDR_W-1:0] wsh;
  logic nblk;
  logic [`SDRC_BANK_W-1:0] nbank;
  logic [`SDRC_ROW_W-1:0] nrow;
  logic [`SDRC_COL_W-1:0] ncol;
  logic [2:0] pidx;
  logic [`SDRC_CNT_W-1:0] lat;

  sdrc_ecc_enc u_enc (
    .data_in(din_in),
    .word_out(enc_word)
  );

  sdrc_ecc_dec u_dec (
    .word_in(sd_dq_in),
    .data_out(dec_data),
    .sbe_out(dec_sbe),
    .dbe_out(dec_dbe)
  );

  function automatic sdrc_cmd_type mk_cmd(input logic [2:0] op,
      input logic blk, input logic [`SDRC_BANK_W-1:0] ba,
      input logic [`SDRC_SDA_W-1:0] a);
    sdrc_cmd_type c;
    c.cs_n = blk ? 2'h1 : 2'h2;
    c.rcw_n = op;
    c.ba = ba;
    c.a = a;
    return c;
  endfunction : mk_cmd

  // First-beat latency from kind, history and page state
  function automatic logic [`SDRC_CNT_W-1:0] first_lat(
      input sdrc_req_type r, input sdrc_page_type p, input logic chain,
      input logic alt, input logic streak);
    logic [`SDRC_CNT_W-1:0] l;
    l = '0;
    if (!r.wr && chain && r.burst) begin
      if (p == SDRC_PG_HIT) begin
        l = alt ? `SDRC_LAT_BRB_HIT_B : `SDRC_LAT_BRB_HIT_A;
      end else begin
        l = `SDRC_LAT_BRB_MISS;
      end
    end else if (!r.wr && chain) begin
      l = (p == SDRC_PG_HIT) ? `SDRC_LAT_SRB_HIT : `SDRC_LAT_SRB_MISS;
    end else if (!r.wr) begin
      case (p)
        SDRC_PG_CLOSED: l = `SDRC_LAT_RD_CLOSED;
        SDRC_PG_MISS: l = `SDRC_LAT_RD_MISS;
        default: l = `SDRC_LAT_RD_HIT;
      endcase
    end else if (chain && r.burst) begin
      if (p == SDRC_PG_HIT) begin
        l = streak ? `SDRC_LAT_BWB_HIT_N : `SDRC_LAT_BWB_HIT_2ND;
      end else begin
        l = `SDRC_LAT_BWB_MISS;
      end
    end else if (chain) begin
      l = (p == SDRC_PG_HIT) ? `SDRC_LAT_SWB_HIT : `SDRC_LAT_SWB_MISS;
    end else begin
      l = r.burst ? `SDRC_LAT_BW_IDLE : `SDRC_LAT_SW_IDLE;
    end
    return l;
  endfunction : first_lat

  // Address split: column, bank, row, then block select
  always_comb begin
    nreq = ((q.st == SDRC_IDLE) || !q.pend_v) ? req_in : q.pend;
    case (cfg_org_in)
      SDRC_ORG_X16: colw = `SDRC_COLW_X16;
      SDRC_ORG_X4: colw = `SDRC_COLW_X4;
      default: colw = `SDRC_COLW_X8;
    endcase
    w = nreq.addr[`SDRC_ADDR_W-1:`SDRC_BEAT_LSB];
    ncol = `SDRC_COL_W'(w & ~(`SDRC_WADDR_W'('1) << colw));
    ncol[1:0] = 2'h0; // Cache-line aligned bursts
    wsh = w >> colw;
    nbank = wsh[`SDRC_BANK_W-1:0];
    nrow = wsh[`SDRC_BANK_W +: `SDRC_ROW_W];
    nblk = (cfg_org_in == SDRC_ORG_X8_TWO) &&
      wsh[`SDRC_BANK_W + `SDRC_ROW_W];
    pidx = {nblk, nbank};
    if (!q.open_v[pidx]) begin
      pg = SDRC_PG_CLOSED;
    end else if (q.open_row[pidx] == nrow) begin
      pg = SDRC_PG_HIT;
    end else begin
      pg = SDRC_PG_MISS;
    end
  end

  assign accept = ce_in && !ts_n_in &&
    ((q.st == SDRC_IDLE) || !q.pend_v);
  assign aack_n_out = !accept;

  always_comb begin
    n = q;
    n.ta = 1'b0;
    n.sbe = 1'b0;
    n.dbe = 1'b0;
    n.dq_oe = 1'b0;
    n.cmd = mk_cmd(`SDRC_CMD_NOP, q.blk, q.bank, '0);
    do_start = 1'b0;
    b2b = 1'b0;
    rd_go = 1'b0;
    same = 1'b0;
    lat = '0;
    if (accept && (q.st != SDRC_IDLE)) begin
      n.pend = req_in;
      n.pend_v = 1'b1;
    end
    case (q.st)
      SDRC_IDLE: begin
        do_start = accept;
      end
      SDRC_WAIT: begin
        // One SDRAM command a clock, each at its lead or as soon as free
        if (q.need_pre && (q.cnt <= (q.wr ? `SDRC_WPRE_LEAD :
            `SDRC_RPRE_LEAD))) begin
          n.cmd = mk_cmd(`SDRC_CMD_PRE, q.blk, q.bank, '0);
          n.need_pre = 1'b0;
          n.open_v[{q.blk, q.bank}] = 1'b0;
        end else if (!q.need_pre && q.need_act && (q.cnt <= (q.wr ?
            `SDRC_WACT_LEAD : `SDRC_RACT_LEAD))) begin
          n.cmd = mk_cmd(`SDRC_CMD_ACT, q.blk, q.bank, q.row);
          n.need_act = 1'b0;
          n.open_v[{q.blk, q.bank}] = 1'b1;
          n.open_row[{q.blk, q.bank}] = q.row;
        end else if (!q.wr && !q.need_pre && !q.need_act && q.need_rw &&
            (q.cmd.rcw_n != `SDRC_CMD_ACT) && // Row to column gap
            (q.cnt <= `SDRC_RD_LEAD)) begin
          n.cmd = mk_cmd(`SDRC_CMD_READ, q.blk, q.bank,
            `SDRC_SDA_W'(q.col));
          n.need_rw = 1'b0;
          rd_go = 1'b1;
        end
        if (q.cnt == `SDRC_CNT_W'(1)) begin
          n.ta = 1'b1;
          n.dout = q.rbuf[0];
          n.idx = 2'h1;
          n.st = q.burst ? SDRC_BEAT : SDRC_TAIL;
        end else begin
          n.cnt = q.cnt - `SDRC_CNT_W'(1);
        end
      end
      SDRC_BEAT: begin
        n.ta = 1'b1;
        n.dout = q.rbuf[q.idx];
        n.idx = q.idx + 2'h1;
        if (q.idx == 2'(`SDRC_BEATS - 1)) begin
          n.st = SDRC_TAIL;
        end
      end
      SDRC_TAIL: begin
        if (q.pend_v || accept) begin
          do_start = 1'b1;
          b2b = 1'b1;
          n.pend_v = 1'b0;
        end else begin
          n.st = SDRC_IDLE;
        end
      end
      default: n.st = SDRC_IDLE;
    endcase

    // Write beats go to the SDRAM the clock after each bus acknowledge
    if (q.ta && q.wr) begin
      n.dq = enc_word;
      n.dq_oe = 1'b1;
      if (q.need_rw) begin
        n.cmd = mk_cmd(`SDRC_CMD_WRITE, q.blk, q.bank,
          `SDRC_SDA_W'(q.col));
        n.need_rw = 1'b0;
      end
    end

    if (do_start) begin
      same = q.last_v && (q.last_wr == nreq.wr) &&
        (q.last_burst == nreq.burst);
      lat = first_lat(nreq, pg, b2b && same, q.rd_alt, q.wr_streak);
      n.cnt = lat - `SDRC_CNT_W'(1);
      n.st = SDRC_WAIT;
      n.wr = nreq.wr;
      n.burst = nreq.burst;
      n.blk = nblk;
      n.bank = nbank;
      n.row = nrow;
      n.col = ncol;
      n.need_pre = (pg == SDRC_PG_MISS);
      n.need_act = (pg != SDRC_PG_HIT);
      n.need_rw = 1'b1;
      n.last_v = 1'b1;
      n.last_wr = nreq.wr;
      n.last_burst = nreq.burst;
      if (b2b && same && !nreq.wr && nreq.burst && (pg == SDRC_PG_HIT)) begin
        n.rd_alt = !q.rd_alt;
      end
      n.wr_streak = b2b && same && nreq.wr && nreq.burst &&
        (pg == SDRC_PG_HIT);
    end

    // Read data returns CAS latency after the command
    n.rd_pipe = {q.rd_pipe[`SDRC_CAS_LAT-2:0], rd_go};
    if (rd_go) begin
      n.rd_all = q.burst;
    end
    if (q.rd_pipe[`SDRC_CAS_LAT-1]) begin
      n.cap_v = 1'b1;
      n.cap_idx = 2'h0;
      n.cap_all = q.rd_all;
    end else if (q.cap_v) begin
      n.cap_idx = q.cap_idx + 2'h1;
      if (q.cap_idx == 2'(`SDRC_BEATS - 1)) begin
        n.cap_v = 1'b0;
      end
    end
    if (q.cap_v) begin
      n.rbuf[q.cap_idx] = dec_data;
      if (q.cap_all || (q.cap_idx == 2'h0)) begin
        n.sbe = dec_sbe;
        n.dbe = dec_dbe;
      end
    end
    // Mask the unused beats of a single write; open lanes for reads
    n.dqm = !(rd_go || (q.rd_pipe != '0) || q.cap_v);
    if (q.ta && q.wr) begin
      n.dqm = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      q <= '0;
      q.st <= SDRC_IDLE;
      q.cmd <= {2'h3, `SDRC_CMD_NOP, `SDRC_BANK_W'(0), `SDRC_SDA_W'(0)};
      q.dqm <= 1'b1;
    end else if (ce_in) begin
      q <= n;
    end
  end

  // Command and data pins leave the state flops directly
  assign sd_cmd_out = q.cmd;
  assign sd_dq_out = q.dq;
  assign sd_dq_oe_out = q.dq_oe;
  assign sd_dqm_out = q.dqm;
  assign ta_n_out = !q.ta;
  assign dout_out = q.dout;
  assign ecc_sbe_out = q.sbe;
  assign ecc_dbe_out = q.dbe;

endmodule : sdrc_ctrl

/* sdrc_defs.svh */
// Constants for the SDRAM controller with ECC: widths, timing, latencies.
// Assumes a single bus clock shared by processor bus and SDRAM.
`ifndef SDRC_DEFS_SVH
`define SDRC_DEFS_SVH

`define SDRC_DATA_W 64
`define SDRC_CHK_W 8
`define SDRC_SYN_W 7
`define SDRC_WORD_W 72
`define SDRC_ADDR_W 27
`define SDRC_BEAT_LSB 3
`define SDRC_WADDR_W 24
`define SDRC_ROW_W 12
`define SDRC_BANK_W 2
`define SDRC_COL_W 10
`define SDRC_SDA_W 12
`define SDRC_BEATS 4
`define SDRC_PAGES 8
`define SDRC_CNT_W 5
`define SDRC_LINE_BYTES 32

// Column widths per device organisation
`define SDRC_COLW_X16 5'd8
`define SDRC_COLW_X8 5'd9
`define SDRC_COLW_X4 5'd10

// SDRAM command timing in clocks
`define SDRC_CAS_LAT 2
`define SDRC_TRCD 2
`define SDRC_TRP 2
`define SDRC_TRAS 5
`define SDRC_TRC 7
`define SDRC_TDPL 2

// Command lead in clocks before first data acknowledge
`define SDRC_RD_LEAD (`SDRC_CAS_LAT + 3)
`define SDRC_RACT_LEAD (`SDRC_RD_LEAD + `SDRC_TRCD)
`define SDRC_RPRE_LEAD (`SDRC_RACT_LEAD + `SDRC_TRP)
`define SDRC_WACT_LEAD (`SDRC_TRCD)
`define SDRC_WPRE_LEAD (`SDRC_TRCD + `SDRC_TRP)

// First-beat latencies in clocks
`define SDRC_LAT_RD_CLOSED 5'd10
`define SDRC_LAT_RD_MISS 5'd12
`define SDRC_LAT_RD_HIT 5'd7
`define SDRC_LAT_BRB_MISS 5'd5
`define SDRC_LAT_BRB_HIT_A 5'd2
`define SDRC_LAT_BRB_HIT_B 5'd3
`define SDRC_LAT_BW_IDLE 5'd4
`define SDRC_LAT_BWB_MISS 5'd6
`define SDRC_LAT_BWB_HIT_2ND 5'd3
`define SDRC_LAT_BWB_HIT_N 5'd2
`define SDRC_LAT_SRB_MISS 5'd8
`define SDRC_LAT_SRB_HIT 5'd5
`define SDRC_LAT_SW_IDLE 5'd5
`define SDRC_LAT_SWB_MISS 5'd13
`define SDRC_LAT_SWB_HIT 5'd8

// SDRAM commands as {ras_n, cas_n, we_n}
`define SDRC_CMD_NOP 3'h7
`define SDRC_CMD_ACT 3'h3
`define SDRC_CMD_READ 3'h5
`define SDRC_CMD_WRITE 3'h4
`define SDRC_CMD_PRE 3'h2

`endif

/* sdrc_pkg.sv */
// Types for the SDRAM controller with ECC.
// Assumes sdrc_defs.svh supplies all widths.
`include "sdrc_defs.svh"
package sdrc_pkg;

  typedef enum logic [3:0] {
    SDRC_IDLE = 4'h1,
    SDRC_WAIT = 4'h2,
    SDRC_BEAT = 4'h4,
    SDRC_TAIL = 4'h8
  } sdrc_st_type;

  typedef enum logic [1:0] {
    SDRC_ORG_X16 = 2'h0,
    SDRC_ORG_X8_ONE = 2'h1,
    SDRC_ORG_X8_TWO = 2'h2,
    SDRC_ORG_X4 = 2'h3
  } sdrc_org_type;

  typedef enum logic [1:0] {
    SDRC_PG_CLOSED = 2'h0,
    SDRC_PG_MISS = 2'h1,
    SDRC_PG_HIT = 2'h2
  } sdrc_page_type;

  typedef struct packed {
    logic wr;
    logic burst;
    logic [`SDRC_ADDR_W-1:0] addr;
  } sdrc_req_type;

  typedef struct packed {
    logic [1:0] cs_n;
    logic [2:0] rcw_n;
    logic [`SDRC_BANK_W-1:0] ba;
    logic [`SDRC_SDA_W-1:0] a;
  } sdrc_cmd_type;

  typedef struct packed {
    sdrc_st_type st;
    logic [`SDRC_CNT_W-1:0] cnt;
    logic [1:0] idx;
    logic wr;
    logic burst;
    logic blk;
    logic [`SDRC_BANK_W-1:0] bank;
    logic [`SDRC_ROW_W-1:0] row;
    logic [`SDRC_COL_W-1:0] col;
    logic need_pre;
    logic need_act;
    logic need_rw;
    logic pend_v;
    sdrc_req_type pend;
    logic last_v;
    logic last_wr;
    logic last_burst;
    logic rd_alt;
    logic wr_streak;
    logic [`SDRC_PAGES-1:0] open_v;
    logic [`SDRC_PAGES-1:0][`SDRC_ROW_W-1:0] open_row;
    logic [`SDRC_CAS_LAT-1:0] rd_pipe;
    logic rd_all;
    logic cap_v;
    logic cap_all;
    logic [1:0] cap_idx;
    logic [`SDRC_BEATS-1:0][`SDRC_DATA_W-1:0] rbuf;
    logic ta;
    logic [`SDRC_DATA_W-1:0] dout;
    sdrc_cmd_type cmd;
    logic [`SDRC_WORD_W-1:0] dq;
    logic dq_oe;
    logic dqm;
    logic sbe;
    logic dbe;
  } sdrc_state_type;

  // Hamming position of data bit j: the j-th non power of two from 3
  function automatic logic [`SDRC_SYN_W-1:0] sdrc_pos(input int j);
    int n;
    int p;
    n = 0;
    sdrc_pos = '0;
    for (p = 3; p < 128; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == j) begin
          sdrc_pos = p[`SDRC_SYN_W-1:0];
        end
        n++;
      end
    end
  endfunction : sdrc_pos

endpackage : sdrc_pkg

/* sdrc_ecc_enc.sv */
// Check-bit generator over a 64-bit data word, giving a 72-bit codeword.
// Assumes nothing beyond the package; purely combinational.
`include "sdrc_defs.svh"
module sdrc_ecc_enc (
  input wire logic [`SDRC_DATA_W-1:0] data_in, // Data word
  output logic [`SDRC_WORD_W-1:0] word_out // Data with check byte
);
  import sdrc_pkg::*;

  logic [`SDRC_SYN_W-1:0] chk;
  logic [`SDRC_SYN_W-1:0] pos;

  // Each data bit folds its position into the check bits
  always_comb begin
    chk = '0;
    pos = '0;
    for (int j = 0; j < `SDRC_DATA_W; j++) begin
      pos = sdrc_pos(j);
      chk = chk ^ ({`SDRC_SYN_W{data_in[j]}} & pos);
    end
  end

  // Top bit makes the whole 72-bit word even parity
  assign word_out = {^{chk, data_in}, chk, data_in};

endmodule : sdrc_ecc_enc

/* sdrc_ecc_dec.sv */
// Corrects one flipped bit and flags two in a 72-bit codeword.
// Assumes codewords made by sdrc_ecc_enc; purely combinational.
`include "sdrc_defs.svh"
module sdrc_ecc_dec (
  input wire logic [`SDRC_WORD_W-1:0] word_in, // Stored codeword
  output logic [`SDRC_DATA_W-1:0] data_out, // Corrected data
  output logic sbe_out, // Single error, corrected
  output logic dbe_out // Double error, uncorrectable
);
  import sdrc_pkg::*;

  logic [`SDRC_WORD_W-1:0] recode;
  logic [`SDRC_SYN_W-1:0] syn;
  logic odd;

  sdrc_ecc_enc u_enc (
    .data_in(word_in[`SDRC_DATA_W-1:0]),
    .word_out(recode)
  );

  always_comb begin
    syn = word_in[`SDRC_WORD_W-2:`SDRC_DATA_W] ^
      recode[`SDRC_WORD_W-2:`SDRC_DATA_W];
    odd = ^word_in;
    for (int j = 0; j < `SDRC_DATA_W; j++) begin
      data_out[j] = word_in[j] ^ (odd && (syn == sdrc_pos(j)));
    end
    sbe_out = odd;
    dbe_out = !odd && (syn != '0);
  end

endmodule : sdrc_ecc_dec

/* sdrc_ctrl_chk.sv */
// Port-level assertions for the SDRAM controller.
// Assumes one clock and a synchronous active-low reset.
`include "sdrc_defs.svh"
module sdrc_chk (
  input wire logic ref_clk_in, // Clock
  input wire logic resetn_in, // Reset, low
  input wire logic ts_n_in, // Transfer start
  input wire logic aack_n_out, // Address ack
  input wire logic ta_n_out, // Transfer ack
  input sdrc_pkg::sdrc_cmd_type sd_cmd_out, // SDRAM command
  input wire logic sd_dq_oe_out, // Data drive
  input wire logic sd_dqm_out, // Data mask
  input wire logic ecc_sbe_out, // Corrected error
  input wire logic ecc_dbe_out // Uncorrectable error
);
  import sdrc_pkg::*;
  logic [2:0] run_q;
  logic [2:0] run_d;
  logic sel;
  logic rd_cmd;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  assign sel = (sd_cmd_out.cs_n != 2'h3);
  assign rd_cmd = sel && (sd_cmd_out.rcw_n == `SDRC_CMD_READ);
  // Length of the current acknowledge run
  always_comb begin
    run_d = ta_n_out ? 3'h0 : run_q + 3'h1;
  end
  always_ff @(posedge ref_clk_in) begin
    run_q <= resetn_in ? run_d : 3'h0;
  end
  a_ta_run: assert property (
    $rose(ta_n_out) |-> (run_q == 3'h1 || run_q == 3'h4))
    else $error("Acknowledge run not one or four beats");
  a_aack_ts: assert property (!aack_n_out |-> !ts_n_in)
    else $error("Address ack without transfer start");
  a_one_block: assert property (sd_cmd_out.cs_n != 2'h0)
    else $error("Both blocks selected");
  a_act_rcd: assert property (
    sel && sd_cmd_out.rcw_n == `SDRC_CMD_ACT |=> !(sel &&
    sd_cmd_out.rcw_n inside {`SDRC_CMD_READ, `SDRC_CMD_WRITE}))
    else $error("Column command too soon after activate");
  a_wdata_ta: assert property (
    sd_dq_oe_out && !sd_dqm_out |-> !$past(ta_n_out))
    else $error("Write data without a preceding acknowledge");
  a_ecc_excl: assert property (!(ecc_sbe_out && ecc_dbe_out))
    else $error("Both error flags at once");
  a_ecc_beat: assert property (
    ecc_sbe_out || ecc_dbe_out |-> $past(rd_cmd, 3) || $past(rd_cmd, 4) ||
    $past(rd_cmd, 5) || $past(rd_cmd, 6))
    else $error("Error flag not tied to a read return");
  a_reset_idle: assert property (
    $rose(resetn_in) |-> ta_n_out && !sel && !sd_dq_oe_out && sd_dqm_out)
    else $error("Outputs not idle after reset");
  c_burst: cover property ($rose(ta_n_out) && run_q == 3'h4);
  c_sbe: cover property (ecc_sbe_out);
  c_dbe: cover property (ecc_dbe_out);
  c_wdata: cover property (sd_dq_oe_out && !sd_dqm_out);
endmodule : sdrc_chk

bind sdrc_ctrl sdrc_chk i_chk (
  .ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in),
  .ts_n_in(ts_n_in),
  .aack_n_out(aack_n_out),
  .ta_n_out(ta_n_out),
  .sd_cmd_out(sd_cmd_out),
  .sd_dq_oe_out(sd_dq_oe_out),
  .sd_dqm_out(sd_dqm_out),
  .ecc_sbe_out(ecc_sbe_out),
  .ecc_dbe_out(ecc_dbe_out)
);

/* sdrc_sdram_mdl.sv */
// Behavioural SDRAM array: stores codewords, returns them at CAS 2.
// Assumes commands and data change just after the rising edge.
`include "sdrc_defs.svh"
module sdrc_sdram_mdl (
  input wire logic ref_clk_in, // Clock
  input sdrc_pkg::sdrc_cmd_type cmd_in, // Command from controller
  input wire logic [`SDRC_WORD_W-1:0] dq_in, // Write data
  input wire logic oe_in, // Write data driven
  input wire logic dqm_in, // Write mask
  input wire logic [`SDRC_WORD_W-1:0] flip_in, // Bits to corrupt
  output logic [`SDRC_WORD_W-1:0] dq_out // Read data
);
  import sdrc_pkg::*;
  logic [`SDRC_WORD_W-1:0] mem[int];
  logic [`SDRC_ROW_W-1:0] row[8];
  int rkey;
  int wkey;
  int rb = 4;
  int wb = 4;
  function automatic int key(input sdrc_cmd_type c);
    return int'({c.cs_n[0], c.ba, row[{c.cs_n[0], c.ba}], c.a[9:2], 2'h0});
  endfunction : key
  initial begin
    dq_out = '0;
  end
  always @(posedge ref_clk_in) begin
    if (rb < 4) begin
      // Beat driven two clocks after the read command
      dq_out <= (mem.exists(rkey + rb) ? mem[rkey + rb] : '0) ^ flip_in;
      rb++;
    end else begin
      dq_out <= ~dq_out;
    end
    if (cmd_in.cs_n != 2'h3) begin
      case (cmd_in.rcw_n)
        `SDRC_CMD_ACT: row[{cmd_in.cs_n[0], cmd_in.ba}] = cmd_in.a;
        `SDRC_CMD_READ: begin
          rkey = key(cmd_in);
          rb = 0;
        end
        `SDRC_CMD_WRITE: begin
          wkey = key(cmd_in);
          wb = 0;
        end
        default: ;
      endcase
    end
    if (wb < 4) begin
      if (oe_in && !dqm_in) begin
        mem[wkey + wb] = dq_in;
      end
      wb++;
    end
  end
endmodule : sdrc_sdram_mdl

/* sdrc_tb.sv */
// Self-checking bench: bus master, result watcher, SDRAM array model.
// Assumes the controller, its checker and the array model compile first.
`include "sdrc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sdrc_pkg::*;
  typedef struct {
    int lat;
    bit chain;
    int ts_edge;
    bit burst;
    bit wr;
    bit chk;
    int line;
  } sdrc_note_type;
  localparam int line_a = 0;
  localparam int line_b = 32768;
  // Block B line when two byte-wide blocks are fitted
  localparam int line_c = 2097152;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ts_n_in = 1'b1;
  sdrc_req_type req_in = '0;
  logic [63:0] din_in = '0;
  logic [71:0] flip_mask = '0;
  sdrc_org_type cfg_org = SDRC_ORG_X4;
  logic [71:0] sd_dq_in;
  logic aack_n_out;
  logic ta_n_out;
  logic [63:0] dout_out;
  sdrc_cmd_type sd_cmd_out;
  logic [71:0] sd_dq_out;
  logic sd_dq_oe_out;
  logic sd_dqm_out;
  logic ecc_sbe_out;
  logic ecc_dbe_out;
  logic [31:0] rng = 32'hf039;
  sdrc_note_type notes[$];
  sdrc_note_type cur;
  logic [63:0] wmem[int];
  int edge_n = 0;
  int last_ta = 0;
  int beat = 0;
  int sl;
  int sbe_n = 0;
  int dbe_n = 0;
  int bad_count = 0;
  int samples_checked = 0;

  sdrc_ctrl i_dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(1'b1),
    .cfg_org_in(cfg_org), .ts_n_in(ts_n_in), .req_in(req_in),
    .din_in(din_in), .aack_n_out(aack_n_out), .ta_n_out(ta_n_out),
    .dout_out(dout_out), .sd_cmd_out(sd_cmd_out), .sd_dq_in(sd_dq_in),
    .sd_dq_out(sd_dq_out), .sd_dq_oe_out(sd_dq_oe_out),
    .sd_dqm_out(sd_dqm_out), .ecc_sbe_out(ecc_sbe_out),
    .ecc_dbe_out(ecc_dbe_out));
  sdrc_sdram_mdl i_mem (
    .ref_clk_in(ref_clk_in), .cmd_in(sd_cmd_out), .dq_in(sd_dq_out),
    .oe_in(sd_dq_oe_out), .dqm_in(sd_dqm_out), .flip_in(flip_mask),
    .dq_out(sd_dq_in));

  always #20 ref_clk_in = ~ref_clk_in;

  function automatic logic [31:0] xs_next(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs_next

  function automatic logic [63:0] exp_word(input int k);
    return wmem.exists(k) ? wmem[k] : 64'h0;
  endfunction : exp_word

  task automatic compare(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : compare

  task automatic final_report();
    $display("Compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  always @(negedge ref_clk_in) begin
    rng = xs_next(rng);
    din_in <= {rng, ~rng};
  end

  // Watcher: pairs each tenure with the oldest note
  always @(posedge ref_clk_in) begin
    edge_n++;
    sbe_n += int'(ecc_sbe_out === 1'b1);
    dbe_n += int'(ecc_dbe_out === 1'b1);
    if (edge_n > 3000) begin
      bad_count++;
      final_report();
    end
    if (ta_n_out === 1'b0 && beat == 0) begin
      if (notes.size() == 0) begin
        compare(64'h1, 64'h0);
      end else begin
        cur = notes.pop_front();
      end
      sl = edge_n - (cur.chain ? last_ta : cur.ts_edge);
      if (cur.wr) begin
        compare(sl, cur.lat);
      end else begin
        compare(sl, cur.lat);
      end
    end else if (ta_n_out === 1'b0) begin
      compare(edge_n - last_ta, 1);
    end
    if (ta_n_out === 1'b0) begin
      if (cur.chk) begin
        compare(dout_out, exp_word(cur.line * 4 + beat));
      end
      if (cur.wr) begin
        wmem[cur.line * 4 + beat] = din_in;
      end
      last_ta = edge_n;
      beat = (cur.burst && beat < 3) ? beat + 1 : 0;
    end
  end

  task automatic quiet();
    int t;
    @(negedge ref_clk_in);
    ts_n_in <= 1'b1;
    for (t = 0; t < 200 && (notes.size() > 0 || beat != 0); t++) begin
      @(negedge ref_clk_in);
    end
    repeat (3) @(negedge ref_clk_in);
  endtask : quiet

  // Chained requests follow the previous acceptance at once
  task automatic issue(input bit wr, input bit burst, input int line,
      input int lat, input bit chain, input bit dchk);
    sdrc_note_type n;
    int t;
    n = '{lat, chain, 0, burst, wr, dchk, line};
    if (!chain) begin
      quiet();
    end
    @(negedge ref_clk_in);
    ts_n_in <= 1'b0;
    req_in <= '{wr, burst, 27'(line * 32)};
    for (t = 0; t < 40; t++) begin
      #1;
      if (aack_n_out === 1'b0) begin
        break;
      end
      @(negedge ref_clk_in);
    end
    if (t == 40) begin
      bad_count++;
    end
    @(posedge ref_clk_in);
    #1;
    n.ts_edge = edge_n;
    notes.push_back(n);
  endtask : issue

  task automatic do_reset();
    @(negedge ref_clk_in);
    resetn_in <= 1'b0;
    repeat (5) @(negedge ref_clk_in);
    resetn_in <= 1'b1;
  endtask : do_reset

  initial begin
    do_reset();
    issue(0, 1, line_a, 10, 0, 1);
    issue(1, 1, line_a, 4, 0, 0);
    issue(0, 1, line_a, 7, 0, 1);
    issue(0, 1, line_b, 12, 0, 1);
    issue(0, 1, line_b, 7, 0, 1);
    issue(0, 1, line_b, 2, 1, 0);
    issue(0, 1, line_b, 3, 1, 0);
    issue(0, 1, line_a, 5, 1, 0);
    issue(1, 1, line_a, 4, 0, 0);
    issue(1, 1, line_a, 3, 1, 0);
    issue(1, 1, line_a, 2, 1, 0);
    issue(1, 1, line_b, 6, 1, 0);
    issue(0, 0, line_a, 12, 0, 1);
    issue(0, 0, line_a, 5, 1, 0);
    issue(0, 0, line_b, 8, 1, 0);
    issue(1, 0, line_b, 5, 0, 0);
    issue(1, 0, line_b, 8, 1, 0);
    issue(1, 0, line_a, 13, 1, 0);
    issue(0, 1, line_b, 12, 0, 1);
    quiet();
    do_reset();
    issue(0, 0, line_a, 10, 0, 1);
    quiet();
    sbe_n = 0;
    dbe_n = 0;
    flip_mask <= 72'h20;
    issue(0, 1, line_a, 7, 0, 1);
    quiet();
    compare(sbe_n, 4);
    compare(dbe_n, 0);
    flip_mask <= 72'h21;
    issue(0, 1, line_a, 7, 0, 0);
    quiet();
    compare(dbe_n, 4);
    flip_mask <= '0;
    cfg_org <= SDRC_ORG_X8_TWO;
    do_reset();
    issue(1, 0, line_c, 5, 0, 0);
    issue(0, 0, line_a, 10, 0, 1);
    issue(0, 0, line_c, 7, 0, 1);
    quiet();
    final_report();
  end
endmodule : testbench
